//--- hdl/pcc_map.svh
// Contract
// [R1] bank select 0 routes pair to compare
// [R2] bank select 1 routes pair to reload
// [R3] reload used only in 9-11 bit modes
// [R4] enable 0 masks overflow interrupt request
// [R5] enable 1 raises request while flag set
// [R6] flag sets on selected counter bit overflow
// [R7] flag set by hardware or software only
// [R8] flag 0 means no overflow since clear
// [R9] flag 1 means overflow since clear
// [R10] length select sets cycle, 0 is 8-bit
// [R11] 16-bit channels ignore length select
// [R12] request is level, drops on flag clear
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH
`define PCC_ADDR_CFG      8'hF7
`define PCC_BIT_BANK      7
`define PCC_BIT_IEN       6
`define PCC_BIT_FLAG      5
`define PCC_LEN_HI        2
`define PCC_LEN_LO        0
`define PCC_LEN_W         3
`define PCC_LEN_8         3'h0
`define PCC_LEN_9         3'h1
`define PCC_LEN_10        3'h2
`define PCC_LEN_11        3'h3
`define PCC_BASE_BIT      7
`define PCC_CNT_W         16
`define PCC_SEL_W         2
`define PCC_RSVD_VAL      2'h0
`define PCC_IDLE_DATA     8'h00
`endif

//--- hdl/pcc_pkg.sv
package pcc_pkg;
   typedef enum logic [0:0] {
      PCC_BANK_COMPARE = 1'b0,
      PCC_BANK_RELOAD  = 1'b1
   } pcc_bank_type;
endpackage

//--- hdl/pcc_edge.sv
`timescale 1ns/100ps
`include "pcc_map.svh"
// overflow out of one selected counter bit: falling edge of that bit
module pcc_edge #(
   parameter int CNT_W = `PCC_CNT_W
) (
   input  wire logic             clk_sys,   // system clock
   input  wire logic             srst,      // sync reset
   input  wire logic [CNT_W-1:0] count,     // main counter value
   input  wire logic [`PCC_LEN_W-1:0] len,  // cycle length select
   output logic                  ovf        // one-cycle overflow pulse
);
   logic                  prev;
   wire  [3:0]            sel_idx;
   wire                   sel_bit;

   assign sel_idx = 4'(`PCC_BASE_BIT) + 4'(len[`PCC_SEL_W-1:0]); // R10
   assign sel_bit = count[sel_idx];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev <= 1'b0;
         ovf  <= 1'b0;
      end else begin
         prev <= sel_bit;
         ovf  <= prev & ~sel_bit; // R6
      end
   end
endmodule

//--- hdl/pcc_top.sv
`timescale 1ns/100ps
`include "pcc_map.svh"
module pcc_top #(
   parameter int CNT_W = `PCC_CNT_W
) (
   input  wire logic             clk_sys,      // system clock, 10 MHz
   input  wire logic             srst,         // sync reset, active high
   input  wire logic [7:0]       sfr_addr,     // register address
   input  wire logic [7:0]       sfr_wdata,    // write data
   input  wire logic             sfr_wr,       // write strobe
   input  wire logic             sfr_rd,       // read strobe
   input  wire logic             pair_wr,      // write to compare pair addr
   input  wire logic             pair_hi,      // 1 high byte, 0 low byte
   input  wire logic [CNT_W-1:0] count,        // main counter value
   input  wire logic             chan_16bit,   // channel in 16-bit mode
   input  wire logic             mode_9_11,    // channel in 9-11 bit mode
   output logic [7:0]            sfr_rdata,    // read data
   output logic                  pair_to_reload, // pair access to reload
   output logic                  reload_use,   // reload value in effect
   output logic [`PCC_LEN_W-1:0] eff_len,      // length seen by channel
   output logic                  ovf_irq       // overflow interrupt request
);
   logic                  bank;
   logic                  ien;
   logic                  flag;
   logic [`PCC_LEN_W-1:0] len;
   logic                  hw_ovf;
   wire                   cfg_wr;
   wire                   cfg_rd;
   wire                   next_bank;
   wire                   next_ien;
   wire                   next_flag;
   wire [`PCC_LEN_W-1:0]  next_len;
   wire [7:0]             cfg_val;

   pcc_edge #(.CNT_W(CNT_W)) u_edge (
      .clk_sys (clk_sys),
      .srst    (srst),
      .count   (count),
      .len     (len),
      .ovf     (hw_ovf)
   );

   assign cfg_wr    = sfr_wr && (sfr_addr == `PCC_ADDR_CFG);
   assign cfg_rd    = sfr_rd && (sfr_addr == `PCC_ADDR_CFG);
   assign next_bank = cfg_wr ? sfr_wdata[`PCC_BIT_BANK] : bank;    // R1 R2
   assign next_ien  = cfg_wr ? sfr_wdata[`PCC_BIT_IEN] : ien;      // R4 R5
   assign next_len  = cfg_wr ? sfr_wdata[`PCC_LEN_HI:`PCC_LEN_LO] :
                      len;                                         // R10
   // hardware set wins over a software clear in the same cycle
   assign next_flag = hw_ovf ? 1'b1 :                              // R6 R7
                      cfg_wr ? sfr_wdata[`PCC_BIT_FLAG] : flag;    // R7
   // reserved bits read back as zero
   assign cfg_val   = {bank, ien, flag, `PCC_RSVD_VAL, len};

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bank <= 1'b0;
         ien  <= 1'b0;
         flag <= 1'b0;
         len  <= `PCC_LEN_8;
      end else begin
         bank <= next_bank;
         ien  <= next_ien;
         flag <= next_flag; // R8 R9
         len  <= next_len;
      end
   end

   // pair_to_reload and ovf_irq follow the next values so they track the register exactly; eff_len does so only while chan_16bit is low
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sfr_rdata      <= `PCC_IDLE_DATA;
         pair_to_reload <= 1'b0;
         reload_use     <= 1'b0;
         eff_len        <= `PCC_LEN_8;
         ovf_irq        <= 1'b0;
      end else begin
         sfr_rdata      <= cfg_rd ? cfg_val : `PCC_IDLE_DATA;
         pair_to_reload <= (next_bank == pcc_pkg::PCC_BANK_RELOAD); // R1 R2
         reload_use     <= mode_9_11 && !chan_16bit; // R3
         eff_len        <= chan_16bit ? `PCC_LEN_8 : next_len; // R10 R11
         ovf_irq        <= next_flag && next_ien; // R4 R5 R12
      end
   end

   property p_irq_level;
      @(posedge clk_sys) disable iff (srst)
         ovf_irq == (flag && ien);
   endproperty
   a_irq_level: assert property (p_irq_level) // R4 R5 R12
      else $error("irq not flag and enable");

   property p_irq_masked;
      @(posedge clk_sys) disable iff (srst)
         !ien |-> !ovf_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) // R4
      else $error("irq raised while masked");

   property p_irq_raised;
      @(posedge clk_sys) disable iff (srst)
         flag && ien |-> ovf_irq;
   endproperty
   a_irq_raised: assert property (p_irq_raised) // R5
      else $error("irq missing with flag and enable");

   property p_irq_drop;
      @(posedge clk_sys) disable iff (srst)
         $fell(flag) |-> !ovf_irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop) // R12
      else $error("irq stayed after flag clear");

   property p_hw_set;
      @(posedge clk_sys) disable iff (srst)
         hw_ovf |=> flag;
   endproperty
   a_hw_set: assert property (p_hw_set) // R6
      else $error("overflow did not set flag");

   property p_no_hw_clear;
      @(posedge clk_sys) disable iff (srst)
         flag && !cfg_wr |=> flag;
   endproperty
   a_no_hw_clear: assert property (p_no_hw_clear) // R7 R9
      else $error("flag cleared without write");

   property p_no_spurious;
      @(posedge clk_sys) disable iff (srst)
         !flag && !hw_ovf && !(cfg_wr && sfr_wdata[`PCC_BIT_FLAG])
         |=> !flag;
   endproperty
   a_no_spurious: assert property (p_no_spurious) // R8
      else $error("flag set without cause");

   property p_sw_set;
      @(posedge clk_sys) disable iff (srst)
         cfg_wr && sfr_wdata[`PCC_BIT_FLAG] |=> flag;
   endproperty
   a_sw_set: assert property (p_sw_set) // R7
      else $error("software write did not set flag");

   property p_sw_clear;
      @(posedge clk_sys) disable iff (srst)
         cfg_wr && !sfr_wdata[`PCC_BIT_FLAG] && !hw_ovf |=> !flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) // R7
      else $error("software write did not clear flag");

   property p_read_flag;
      @(posedge clk_sys) disable iff (srst)
         cfg_rd |=> sfr_rdata[`PCC_BIT_FLAG] == $past(flag);
   endproperty
   a_read_flag: assert property (p_read_flag) // R8 R9
      else $error("flag read back wrong");

   property p_bank;
      @(posedge clk_sys) disable iff (srst)
         pair_to_reload == (bank == pcc_pkg::PCC_BANK_RELOAD);
   endproperty
   a_bank: assert property (p_bank) // R1 R2
      else $error("pair routing wrong");

   property p_bank_wr;
      @(posedge clk_sys) disable iff (srst)
         cfg_wr |=> bank == $past(sfr_wdata[`PCC_BIT_BANK]);
   endproperty
   a_bank_wr: assert property (p_bank_wr) // R1 R2
      else $error("bank select not written");

   property p_bank_hold;
      @(posedge clk_sys) disable iff (srst)
         !cfg_wr |=> $stable(bank);
   endproperty
   a_bank_hold: assert property (p_bank_hold) // R1 R2
      else $error("bank select changed without write");

   property p_ien_wr;
      @(posedge clk_sys) disable iff (srst)
         cfg_wr |=> ien == $past(sfr_wdata[`PCC_BIT_IEN]);
   endproperty
   a_ien_wr: assert property (p_ien_wr) // R4 R5
      else $error("irq enable not written");

   property p_reload;
      @(posedge clk_sys) disable iff (srst)
         chan_16bit |=> !reload_use;
   endproperty
   a_reload: assert property (p_reload) // R3
      else $error("reload used outside 9-11 bit");

   property p_reload_off;
      @(posedge clk_sys) disable iff (srst)
         !mode_9_11 |=> !reload_use;
   endproperty
   a_reload_off: assert property (p_reload_off) // R3
      else $error("reload used in other mode");

   property p_reload_on;
      @(posedge clk_sys) disable iff (srst)
         mode_9_11 && !chan_16bit |=> reload_use;
   endproperty
   a_reload_on: assert property (p_reload_on) // R3
      else $error("reload missing in 9-11 bit");

   property p_len16;
      @(posedge clk_sys) disable iff (srst)
         chan_16bit |=> eff_len == `PCC_LEN_8;
   endproperty
   a_len16: assert property (p_len16) // R11
      else $error("16-bit channel saw length");

   property p_len;
      @(posedge clk_sys) disable iff (srst)
         !chan_16bit |=> eff_len == len;
   endproperty
   a_len: assert property (p_len) // R10
      else $error("length not passed");

   property p_len_wr;
      @(posedge clk_sys) disable iff (srst)
         cfg_wr |=> len == $past(sfr_wdata[`PCC_LEN_HI:`PCC_LEN_LO]);
   endproperty
   a_len_wr: assert property (p_len_wr) // R10
      else $error("length select not written");

   property p_len_hold;
      @(posedge clk_sys) disable iff (srst)
         !cfg_wr |=> $stable(len);
   endproperty
   a_len_hold: assert property (p_len_hold) // R10
      else $error("length select changed without write");
endmodule

//--- test/pcc_testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module testbench;
   logic        clk_sys = 0, srst = 1, sfr_wr = 0, sfr_rd = 0;
   logic        pair_wr = 0, pair_hi = 0, chan_16bit = 0, mode_9_11 = 0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
   logic [15:0] count = 16'h0000;
   logic        pair_to_reload, reload_use, ovf_irq;
   logic [2:0]  eff_len;
   int          bad_count = 0, num_checks = 0;
   pcc_top i_dut (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .pair_wr(pair_wr), .pair_hi(pair_hi), .count(count),
      .chan_16bit(chan_16bit), .mode_9_11(mode_9_11), .sfr_rdata(sfr_rdata),
      .pair_to_reload(pair_to_reload), .reload_use(reload_use),
      .eff_len(eff_len), .ovf_irq(ovf_irq));
   always #50 clk_sys = ~clk_sys;
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge clk_sys);
      sfr_wr    = 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge clk_sys);
      sfr_rd   = 1'b0;
      d        = sfr_rdata;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      srst = 1'b0;
      rd(8'hF7, r);
      `CHK(r, 8'h00)
      `CHK(ovf_irq, 1'b0)
      `CHK(reload_use, 1'b0)
      wr(8'hF7, 8'hFF);
      rd(8'hF7, r);
      `CHK(r, 8'hE7)
      `CHK(pair_to_reload, 1'b1)
      `CHK(ovf_irq, 1'b1)
      wr(8'hF7, 8'h40);
      `CHK(ovf_irq, 1'b0)
      `CHK(pair_to_reload, 1'b0)
      wr(8'hF7, 8'h20);
      `CHK(ovf_irq, 1'b0)
      wr(8'h9C, 8'h00);
      rd(8'h9C, r);
      `CHK(r, 8'h00)
      rd(8'hF7, r);
      `CHK(r, 8'h20)
      for (int l = 0; l < 4; l++) begin
         wr(8'hF7, 8'h40 | l[7:0]);
         `CHK(eff_len, l[2:0])
         count = 16'h0001 << (7 + l);
         repeat (4) @(negedge clk_sys);
         rd(8'hF7, r);
         `CHK(r, 8'h40 | l[7:0])
         count = 16'h0000;
         repeat (4) @(negedge clk_sys);
         rd(8'hF7, r);
         `CHK(r, 8'h60 | l[7:0])
         `CHK(ovf_irq, 1'b1)
      end
      chan_16bit = 1'b1;
      mode_9_11 = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK(eff_len, 3'h0)
      `CHK(reload_use, 1'b0)
      chan_16bit = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK(reload_use, 1'b1)
      wr(8'hF7, 8'h43);
      count = 16'h0400;
      repeat (2) @(negedge clk_sys);
      count = 16'h0000;
      // clear lands on the edge of the hardware set
      wr(8'hF7, 8'h43);
      rd(8'hF7, r);
      `CHK(r, 8'h63)
      end_sim();
   end
endmodule
